// ==== ata_transfer_control_regs.sv ====
// transfer control and count register bank for the drive interface
`timescale 1ns/1ps
module ata_transfer_control_regs
   import ata_xfer_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   // avalon-mm slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   // drive data engine side
   input wire logic xfer_beat_i,
   input wire logic xfer_two_bytes_i,
   input wire logic xfer_stop_i,
   input wire logic packet_end_i,
   input wire pio_evt_s pio_i,
   input wire drive_pins_s drive_pins_i,
   output drive_pins_s drive_pins_o,
   output logic drive_pins_oe_o,
   output logic xfer_active_o,
   output logic udma_enable_o,
   output logic auto_transfer_o,
   output logic buffer_b_sel_o,
   output logic irq_o
);

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic active_q;
   logic active_d;
   logic buf_b_q;
   logic [7:0] pio_low_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic [1:0] resp_q;
   drive_pins_s pins_q;
   logic oe_q;
   logic irq_q;

   // bus decode: one wait state, answer on the second edge of the request
   wire req = (avs_read_i | avs_write_i) & ~ack_q;
   wire [7:0] idx = avs_address_i[9:2];
   wire be0 = avs_byteenable_i[0];
   wire wr_go = avs_write_i & ~ack_q & be0;
   wire [7:0] wb = avs_writedata_i[7:0];
   wire hit_ctrl = (idx == IDX_CTRL);
   wire hit_cnt0 = (idx == IDX_CNT0);
   wire hit_cnt1 = (idx == IDX_CNT1);
   wire hit_cnt2 = (idx == IDX_CNT2);
   wire hit_cnt3 = (idx == IDX_CNT3);
   wire hit_pio = (idx == IDX_PIO);
   wire hit_stat = (idx == IDX_IRQ_STAT);
   wire hit_mask = (idx == IDX_IRQ_MASK);
   wire hit_buf = (idx == IDX_BUF);
   wire mapped = hit_ctrl | hit_cnt0 | hit_cnt1 | hit_cnt2 | hit_cnt3 |
      hit_pio | hit_stat | hit_mask | hit_buf;
   wire wr_ctrl = wr_go & hit_ctrl;
   wire start_xfer = wr_go & hit_cnt0;
   wire abort_req = wr_ctrl & wb[CTL_ABORT];

   // transfer engine events
   wire [31:0] step = xfer_two_bytes_i ? 32'h0000_0002 : 32'h0000_0001;
   wire beat = active_q & xfer_beat_i;
   wire last_beat = beat & (cnt_q <= step);
   wire early_end = active_q & xfer_stop_i & ~last_beat;
   wire err_evt = early_end | (abort_req & active_q);
   wire swap_on = ctrl_q[CTL_SWAP] | ctrl_q[CTL_AUTO];

   // count and active next state
   always_comb begin
      cnt_d = cnt_q;
      active_d = active_q;
      if (wr_go & hit_cnt1) cnt_d[15:8] = wb;
      if (wr_go & hit_cnt2) cnt_d[23:16] = wb;
      if (wr_go & hit_cnt3) cnt_d[31:24] = wb;
      if (beat) cnt_d = last_beat ? 32'h0000_0000 : cnt_q - step;
      if (last_beat | early_end | abort_req) active_d = 1'b0;
      if (start_xfer) begin
         cnt_d[7:0] = wb;
         active_d = 1'b1;
      end
   end

   // control register next state
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d[CTL_OUT_EN] = wb[CTL_OUT_EN];
         ctrl_d[CTL_SWAP] = wb[CTL_SWAP];
         ctrl_d[CTL_AUTO] = wb[CTL_AUTO];
         ctrl_d[CTL_UDMA] = wb[CTL_UDMA];
         if (wb[CTL_PIO_DONE]) ctrl_d[CTL_PIO_DONE] = 1'b0;
         if (wb[CTL_ABORT]) ctrl_d[CTL_ABORT] = 1'b1;
      end
      if (abort_req) ctrl_d[CTL_ERROR] = 1'b1;
      if (pio_i.start) ctrl_d[CTL_PIO_DONE] = 1'b0;
      if (start_xfer) begin
         ctrl_d[CTL_ABORT] = 1'b0;
         ctrl_d[CTL_ERROR] = 1'b0;
      end
      if (err_evt) ctrl_d[CTL_ERROR] = 1'b1;
      if (pio_i.done) ctrl_d[CTL_PIO_DONE] = 1'b1;
      ctrl_d[CTL_RSVD] = 1'b0;
   end

   // sticky interrupt status: set wins over write-one clear
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_go & hit_stat) irq_stat_d = irq_stat_q & ~wb[IRQ_W-1:0];
      irq_stat_d[IRQ_PIO] = irq_stat_d[IRQ_PIO] | pio_i.done;
      irq_stat_d[IRQ_ERR] = irq_stat_d[IRQ_ERR] | err_evt;
      irq_stat_d[IRQ_DONE] = irq_stat_d[IRQ_DONE] | last_beat;
   end

   // read mux, reserved control bit reads one, unused bits zero
   wire [7:0] ctrl_rd = ctrl_q | (8'h01 << CTL_RSVD);
   wire [7:0] buf_rd = ({7'h00, ~buf_b_q} << BUF_A) |
      ({7'h00, buf_b_q} << BUF_B);
   wire [7:0] rd_byte =
      hit_ctrl ? ctrl_rd :
      hit_cnt0 ? cnt_q[7:0] :
      hit_cnt1 ? cnt_q[15:8] :
      hit_cnt2 ? cnt_q[23:16] :
      hit_cnt3 ? cnt_q[31:24] :
      hit_pio ? pio_low_q :
      hit_stat ? {5'h00, irq_stat_q} :
      hit_mask ? {5'h00, irq_mask_q} :
      hit_buf ? buf_rd : 8'h00;

   // drive pin gating
   wire out_en = ctrl_q[CTL_OUT_EN];

   // register state
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctrl_q <= CTRL_RESET;
         cnt_q <= CNT_RESET;
         active_q <= 1'b0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         cnt_q <= cnt_d;
         active_q <= active_d;
         irq_stat_q <= irq_stat_d;
         if (wr_go & hit_mask) irq_mask_q <= wb[IRQ_W-1:0];
      end
   end

   // buffer selection: swaps on packet end only while running cleanly
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         buf_b_q <= 1'b0;
      end else if (active_q & packet_end_i & swap_on & ~err_evt) begin
         buf_b_q <= ~buf_b_q;
      end
   end

   // pio read byte capture
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pio_low_q <= 8'h00;
      end else if (pio_i.done & pio_i.is_read) begin
         pio_low_q <= pio_i.rdata;
      end
   end

   // bus answer registers
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         resp_q <= 2'b00;
      end else begin
         ack_q <= req;
         rdata_q <= req ? {24'h000000, rd_byte} : 32'h0000_0000;
         resp_q <= (req & ~mapped) ? 2'b10 : 2'b00;
      end
   end

   // output flops
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pins_q <= '0;
         oe_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         pins_q <= out_en ? drive_pins_i : '0;
         oe_q <= out_en;
         irq_q <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = ~ack_q;
   assign avs_response_o = resp_q;
   assign drive_pins_o = pins_q;
   assign drive_pins_oe_o = oe_q;
   assign xfer_active_o = active_q;
   assign udma_enable_o = ctrl_q[CTL_UDMA];
   assign auto_transfer_o = ctrl_q[CTL_AUTO];
   assign buffer_b_sel_o = buf_b_q;
   assign irq_o = irq_q;

   // checks
   sequence s_cnt0_write;
      wr_go && hit_cnt0;
   endsequence

   a_start_clears_err: assert property (@(posedge core_clk_i)
      disable iff (reset_i) s_cnt0_write and !err_evt |=>
      !ctrl_q[CTL_ERROR] && !ctrl_q[CTL_ABORT] && active_q)
      else $error("start did not clear error");
   a_abort_sets_err: assert property (@(posedge core_clk_i)
      disable iff (reset_i) abort_req && !start_xfer |=>
      ctrl_q[CTL_ERROR] && !active_q)
      else $error("abort did not flag error");
   a_early_end_err: assert property (@(posedge core_clk_i)
      disable iff (reset_i) early_end && !start_xfer |=>
      ctrl_q[CTL_ERROR])
      else $error("early end not flagged");
   a_pio_done_set: assert property (@(posedge core_clk_i)
      disable iff (reset_i) pio_i.done |=>
      ctrl_q[CTL_PIO_DONE] && irq_stat_q[IRQ_PIO])
      else $error("pio completion lost");
   a_pio_w1c: assert property (@(posedge core_clk_i)
      disable iff (reset_i) wr_ctrl && wb[CTL_PIO_DONE] && !pio_i.done
      |=> !ctrl_q[CTL_PIO_DONE])
      else $error("pio flag not cleared");
   a_pio_start_clr: assert property (@(posedge core_clk_i)
      disable iff (reset_i) pio_i.start && !pio_i.done
      |=> !ctrl_q[CTL_PIO_DONE])
      else $error("pio start kept flag");
   a_count_dec: assert property (@(posedge core_clk_i)
      disable iff (reset_i) beat && !last_beat && !start_xfer
      |=> cnt_q == $past(cnt_q) - $past(step))
      else $error("count not decremented");
   a_last_ends: assert property (@(posedge core_clk_i)
      disable iff (reset_i) last_beat && !start_xfer
      |=> cnt_q == 32'h0000_0000 && !active_q)
      else $error("transfer did not end at zero");
   a_rsvd_one: assert property (@(posedge core_clk_i)
      disable iff (reset_i) ack_q && hit_ctrl && avs_read_i
      |-> avs_readdata_o[CTL_RSVD])
      else $error("reserved bit read zero");
   a_pins_float: assert property (@(posedge core_clk_i)
      disable iff (reset_i) !ctrl_q[CTL_OUT_EN] |=>
      !drive_pins_oe_o)
      else $error("pins driven while disabled");
   a_err_keeps_buf: assert property (@(posedge core_clk_i)
      disable iff (reset_i) err_evt |=> $stable(buf_b_q))
      else $error("buffer changed on error");
   a_bus_answer: assert property (@(posedge core_clk_i)
      disable iff (reset_i) req |=> !avs_waitrequest_o ##1
      avs_waitrequest_o)
      else $error("bus answer timing wrong");

endmodule : ata_transfer_control_regs

// ==== ata_xfer_pkg.sv ====
// package: register map, field positions and carriers for the transfer bank
package ata_xfer_pkg;
   // register word indices (all printed offsets are indices, byte addr = 4x)
   localparam logic [7:0] IDX_CTRL = 8'hdd;
   localparam logic [7:0] IDX_CNT0 = 8'he1;
   localparam logic [7:0] IDX_CNT1 = 8'he2;
   localparam logic [7:0] IDX_CNT2 = 8'he3;
   localparam logic [7:0] IDX_CNT3 = 8'he4;
   localparam logic [7:0] IDX_PIO = 8'he8;
   localparam logic [7:0] IDX_IRQ_STAT = 8'he9;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hea;
   localparam logic [7:0] IDX_BUF = 8'heb;
   // control bit positions
   localparam int CTL_OUT_EN = 7;
   localparam int CTL_PIO_DONE = 6;
   localparam int CTL_ABORT = 5;
   localparam int CTL_ERROR = 4;
   localparam int CTL_SWAP = 3;
   localparam int CTL_AUTO = 2;
   localparam int CTL_RSVD = 1;
   localparam int CTL_UDMA = 0;
   // interrupt status bits
   localparam int IRQ_PIO = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_DONE = 2;
   localparam int IRQ_W = 3;
   // buffer bits in bulk endpoint control view
   localparam int BUF_A = 4;
   localparam int BUF_B = 5;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam logic [2:0] DRIVE_ADDR_DATA = 3'h0;

   // drive-side pins gated by the output enable bit
   typedef struct packed {
      logic [2:0] addr;
      logic rd_n;
      logic wr_n;
      logic cs1_n;
      logic cs0_n;
      logic dack;
      logic [15:0] data;
   } drive_pins_s;

   // one pio request from the processor to the drive window
   typedef struct packed {
      logic start;
      logic done;
      logic is_read;
      logic [7:0] rdata;
   } pio_evt_s;
endpackage : ata_xfer_pkg

// ==== drive_engine_model.sv ====
// behavioural drive-side engine: beats, stops, packet ends, pio events
`timescale 1ns/1ps
module drive_engine_model
   import ata_xfer_pkg::*;
(
   input wire logic core_clk_i,
   output logic xfer_beat_o,
   output logic xfer_two_bytes_o,
   output logic xfer_stop_o,
   output logic packet_end_o,
   output pio_evt_s pio_o,
   output drive_pins_s drive_pins_o
);
   logic [23:0] walk_q = 24'h5a3c96;
   // pins change every cycle so a stale registered copy shows up
   always_ff @(posedge core_clk_i) begin
      walk_q <= {walk_q[22:0], ~walk_q[23]};
   end
   assign drive_pins_o = drive_pins_s'(walk_q);
   // quiet levels before the first event, so no unknown reaches the bank
   initial begin
      xfer_beat_o = 1'b0;
      xfer_two_bytes_o = 1'b0;
      xfer_stop_o = 1'b0;
      packet_end_o = 1'b0;
      pio_o = '0;
   end
   // one-cycle events, called just after a rising edge
   task automatic pulse(input logic [4:0] k, input logic t,
                        input logic [7:0] v);
      xfer_beat_o <= k[0];
      xfer_two_bytes_o <= t;
      xfer_stop_o <= k[1];
      packet_end_o <= k[2];
      pio_o <= '{start: k[3], done: k[4], is_read: 1'b1, rdata: v};
      @(posedge core_clk_i);
      xfer_beat_o <= 1'b0;
      xfer_stop_o <= 1'b0;
      packet_end_o <= 1'b0;
      // read data is gone once done has passed
      pio_o <= '{start: 1'b0, done: 1'b0, is_read: 1'b1, rdata: ~v};
      @(posedge core_clk_i);
   endtask : pulse
endmodule : drive_engine_model

// ==== ata_transfer_control_regs_tb_top.sv ====
// self-checking bench for the transfer control register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      fails++; \
      $display("[ERR] %s exp %h got %h", n, e, a); \
   end \
end
module ata_transfer_control_regs_tb_top;
   import ata_xfer_pkg::*;
   logic core_clk_i, reset_i, rd_q, wr_q, waitreq, beat, two, stop, pkt;
   logic oe, active, udma, auto, bsel, irq, i0;
   logic [1:0] resp, rs;
   logic [9:0] addr_q;
   logic [31:0] wdat_q, rdata;
   logic [7:0] d;
   logic [16:0] rows [8];
   pio_evt_s pio;
   drive_pins_s pins_in, pins_out, p;
   int fails = 0;
   int num_checks = 0;
   // clock generation
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   ata_transfer_control_regs ata_transfer_control_regs_i (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .avs_address_i(addr_q),
      .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdat_q),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
      .avs_waitrequest_o(waitreq), .avs_response_o(resp),
      .xfer_beat_i(beat), .xfer_two_bytes_i(two), .xfer_stop_i(stop),
      .packet_end_i(pkt), .pio_i(pio), .drive_pins_i(pins_in),
      .drive_pins_o(pins_out), .drive_pins_oe_o(oe), .xfer_active_o(active),
      .udma_enable_o(udma), .auto_transfer_o(auto),
      .buffer_b_sel_o(bsel), .irq_o(irq));
   drive_engine_model drive_engine_model_i (
      .core_clk_i(core_clk_i), .xfer_beat_o(beat),
      .xfer_two_bytes_o(two), .xfer_stop_o(stop), .packet_end_o(pkt),
      .pio_o(pio), .drive_pins_o(pins_in));
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // one avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
      int n;
      @(posedge core_clk_i);
      addr_q <= {idx, 2'b00};
      wdat_q <= {24'h0, wd};
      wr_q <= w;
      rd_q <= ~w;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         fails++;
         close_out();
      end
      d = rdata[7:0];
      rs = resp;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      bus(1'b1, idx, wd);
   endtask : wr
   task automatic chk(input logic [7:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      `CHK($sformatf("reg %h", idx), e, d)
   endtask : chk
   task automatic ev(input logic [4:0] k, input logic t, input logic [7:0] v);
      drive_engine_model_i.pulse(k, t, v);
   endtask : ev
   // main sequence: table rows first, then hand-written cases
   initial begin
      reset_i = 1'b1;
      rd_q = 1'b0;
      wr_q = 1'b0;
      addr_q = '0;
      wdat_q = '0;
      rows = '{17'h0dd02, 17'h0e400, 17'h0e900, 17'h1dd8d, 17'h0dd8f,
               17'h1dd12, 17'h0dd02, 17'h0ea00};
      repeat (5) @(posedge core_clk_i);
      reset_i <= 1'b0;
      foreach (rows[k]) begin
         if (rows[k][16])
            wr(rows[k][15:8], rows[k][7:0]);
         else
            chk(rows[k][15:8], rows[k][7:0]);
      end
      wr(8'hdd, 8'h85);
      `CHK("udma", 1'b1, udma)
      `CHK("auto", 1'b1, auto)
      $display("table rows done");
      // count load, decrement and end at zero
      wr(8'he4, 8'h00);
      wr(8'he3, 8'h00);
      wr(8'he2, 8'h01);
      wr(8'he1, 8'h04);
      `CHK("active", 1'b1, active)
      ev(5'h01, 1'b1, 8'h00);
      ev(5'h01, 1'b1, 8'h00);
      ev(5'h01, 1'b0, 8'h00);
      chk(8'he1, 8'hff);
      chk(8'he2, 8'h00);
      wr(8'he1, 8'h03);
      ev(5'h01, 1'b1, 8'h00);
      ev(5'h01, 1'b1, 8'h00);
      chk(8'he1, 8'h00);
      `CHK("active", 1'b0, active)
      chk(8'hdd, 8'h87);
      $display("count test done");
      // buffer swapping, early stop keeps buffer and count
      wr(8'he1, 8'h08);
      ev(5'h04, 1'b0, 8'h00);
      chk(8'heb, 8'h20);
      `CHK("buf b", 1'b1, bsel)
      wr(8'hdd, 8'h88);
      ev(5'h04, 1'b0, 8'h00);
      chk(8'heb, 8'h10);
      ev(5'h01, 1'b0, 8'h00);
      ev(5'h02, 1'b0, 8'h00);
      chk(8'hdd, 8'h9a);
      chk(8'he1, 8'h07);
      ev(5'h04, 1'b0, 8'h00);
      chk(8'heb, 8'h10);
      $display("buffer test done");
      // abort and restart
      wr(8'he1, 8'h05);
      chk(8'hdd, 8'h8a);
      wr(8'hdd, 8'ha8);
      chk(8'hdd, 8'hba);
      `CHK("active", 1'b0, active)
      wr(8'he1, 8'h01);
      chk(8'hdd, 8'h8a);
      $display("abort test done");
      // pio completion, clears and interrupt
      wr(8'he9, 8'h07);
      ev(5'h08, 1'b0, 8'h00);
      ev(5'h10, 1'b0, 8'h5a);
      chk(8'hdd, 8'hca);
      chk(8'he8, 8'h5a);
      chk(8'he9, 8'h01);
      i0 = irq;
      wr(8'hea, 8'h07);
      repeat (2) @(posedge core_clk_i);
      `CHK("irq mask", 1'b1, i0 ^ irq)
      ev(5'h08, 1'b0, 8'h00);
      chk(8'hdd, 8'h8a);
      ev(5'h10, 1'b0, 8'h33);
      wr(8'hdd, 8'h8a);
      chk(8'hdd, 8'hca);
      wr(8'hdd, 8'hca);
      chk(8'hdd, 8'h8a);
      wr(8'he9, 8'h07);
      chk(8'he9, 8'h00);
      $display("pio test done");
      // output enable gates the drive pins
      @(posedge core_clk_i);
      p = pins_in;
      #1;
      `CHK("pins", p, pins_out)
      wr(8'hdd, 8'h0a);
      @(posedge core_clk_i);
      #1;
      `CHK("oe", 1'b0, oe)
      `CHK("pins off", 24'h0, pins_out)
      bus(1'b0, 8'h10, 8'h00);
      `CHK("unmapped", 8'h00, d)
      `CHK("resp err", 2'b10, rs)
      chk(8'hdd, 8'h0a);
      `CHK("resp ok", 2'b00, rs)
      $display("pins and unmapped done");
      // reset in mid-run
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      chk(8'hdd, 8'h02);
      chk(8'he1, 8'h00);
      $display("reset test done");
      close_out();
   end
endmodule : ata_transfer_control_regs_tb_top
